// ==== hw/tdpp_core.sv ====
// core end of one channel's transmit data phase: acknowledges
// descriptors, throttles payload with the stall output and passes
// accepted words through a two-entry buffer toward the link.
// assumes the application keeps its side of the handshake and that
// link_busy and desc_grant come from logic on core_clk.
//
// Functional notes
// (R1) framing rises with request for payload packets
// (R2) framing held until cycle before last phase
// (R3) valid from cycle after framing through end
// (R4) word taken only on valid and no stall
// (R5) no first word before its descriptor acknowledge
// (R6) three-dword header: first word with acknowledge
// (R7) stall while link serves other traffic
// (R8) stall while descriptor waits unacknowledged
// (R9) application ignores stall when valid low
// (R10) payload is one 64-bit word per phase
// (R11) address bit 2 chosen by header size
// (R12) address bit picks first doubleword lane
// (R13) one complete signal set per channel
// (R14) request and descriptor held until acknowledge
// (R15) acknowledge is one cycle; next follows directly
// (R16) descriptor bit 126 marks payload present
// (R17) application sends exactly the stated doublewords
// (R18) words leave in received order
`timescale 1ns/100ps
`default_nettype none
module tdpp_core
	import tdpp_pkg::*;
#(
	parameter int WIDE_X8 = 0,
	parameter int VC_ID = 0
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// port toward the application
	tdpp_if.core port,
	// scheduler of the link
	input wire logic desc_grant,
	input wire logic link_busy,
	// descriptors handed on
	output logic [DESC_W-1:0] fwd_desc,
	output logic fwd_desc_valid,
	// payload toward the link
	output logic link_valid,
	input wire logic link_ready,
	output logic [DATA_W-1:0] link_data,
	output logic link_first,
	output logic link_last,
	output logic link_hi_start,
	// current state for observation
	output logic data_phase_busy
);
	localparam int ENT_W = DATA_W + 3;
	localparam int MAX_VC = WIDE_X8 != 0 ? MAX_VC_X8 : MAX_VC_NARROW;
	// each channel gets its own instance and its own interface
	localparam int VC_OK = (VC_ID < MAX_VC) ? 1 : 0; // see (R13)

	typedef enum logic [1:0] {
		TDPP_D_IDLE = 2'b01,
		TDPP_D_DATA = 2'b10
	} tdpp_dstate_t;

	tdpp_dstate_t state;
	logic [WCNT_W-1:0] words_left;
	logic first_pend;
	logic hi_start;
	logic ack;
	logic early_ok;
	logic may_take;
	logic take;
	logic last_word;
	logic [WCNT_W-1:0] words_now;
	logic a2_now;

	// buffer
	logic [ENT_W-1:0] buf_mem [0:BUF_DEPTH-1];
	logic wr_idx;
	logic rd_idx;
	logic [1:0] buf_cnt;
	logic buf_full;
	logic buf_pop;
	logic [ENT_W-1:0] buf_in;

	assign a2_now = port.desc[DESC_HDR_4DW] ? port.desc[DESC_ADDR2_4DW]
		: port.desc[DESC_ADDR2_3DW]; // see (R11)
	assign words_now = tdpp_words(port.desc);

	// acknowledge only between packets, one cycle per descriptor
	assign ack = (VC_OK != 0) & port.req & desc_grant
		& (state == TDPP_D_IDLE); // see (R15)
	assign port.ack = ack;

	// first word may ride the acknowledge only for short headers
	assign early_ok = ack & port.desc[DESC_HAS_DATA]
		& ~port.desc[DESC_HDR_4DW]; // see (R6) (R16)
	assign may_take = (state == TDPP_D_DATA | early_ok) // see (R5) (R8)
		& ~link_busy & ~buf_full; // see (R7)
	assign port.payload_stall = ~may_take;
	assign take = port.payload_valid & may_take; // see (R4)

	assign last_word = (state == TDPP_D_DATA) ? (words_left == 11'h001)
		: (words_now == 11'h001);
	assign data_phase_busy = (state == TDPP_D_DATA);

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			state <= TDPP_D_IDLE;
		else
		begin
			case (state)
				TDPP_D_IDLE:
					if (ack && port.desc[DESC_HAS_DATA] && !(take && last_word))
						state <= TDPP_D_DATA;
				TDPP_D_DATA:
					if (take && last_word)
						state <= TDPP_D_IDLE;
				default:
					state <= TDPP_D_IDLE;
			endcase
		end
	end

	// phase counting; a word taken with the acknowledge counts at once
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			words_left <= '0;
			first_pend <= 1'b0;
			hi_start <= 1'b0;
		end
		else if (ack)
		begin
			words_left <= take ? words_now - 11'h001 : words_now;
			first_pend <= ~take;
			hi_start <= a2_now; // see (R12)
		end
		else if (take)
		begin
			words_left <= words_left - 11'h001;
			first_pend <= 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			fwd_desc <= '0;
			fwd_desc_valid <= 1'b0;
		end
		else
		begin
			fwd_desc_valid <= ack;
			if (ack)
				fwd_desc <= port.desc;
		end
	end

	// two entries let a link stall land without losing a word
	assign buf_full = (buf_cnt == 2'h2);
	assign buf_pop = link_valid & link_ready;
	assign buf_in = {(ack ? 1'b1 : first_pend), last_word,
		(ack ? a2_now : hi_start), port.data}; // see (R10)

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			wr_idx <= 1'b0;
			rd_idx <= 1'b0;
			buf_cnt <= 2'h0;
		end
		else
		begin
			if (take)
				wr_idx <= ~wr_idx;
			if (buf_pop)
				rd_idx <= ~rd_idx; // see (R18)
			case ({take, buf_pop})
				2'b10: buf_cnt <= buf_cnt + 2'h1;
				2'b01: buf_cnt <= buf_cnt - 2'h1;
				default: buf_cnt <= buf_cnt;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end
		else if (take)
			buf_mem[wr_idx] <= buf_in;
	end

	// buffer head is already a flip-flop, so the link sees registered data
	assign link_valid = (buf_cnt != 2'h0);
	assign link_data = buf_mem[rd_idx][DATA_W-1:0];
	assign link_hi_start = buf_mem[rd_idx][DATA_W];
	assign link_last = buf_mem[rd_idx][DATA_W+1];
	assign link_first = buf_mem[rd_idx][DATA_W+2];
endmodule
`default_nettype wire

// ==== hw/tdpp_pkg.sv ====
// constants shared by the application end and the core end of the
// transmit data phase port; assumes one core clock for both ends
package tdpp_pkg;
	localparam int DATA_W = 64;
	localparam int DESC_W = 128;
	localparam int DW_W = 32;
	// descriptor fields
	localparam int DESC_HAS_DATA = 126;
	localparam int DESC_HDR_4DW = 125;
	localparam int DESC_ADDR2_4DW = 2;
	localparam int DESC_ADDR2_3DW = 34;
	localparam int DESC_LEN_HI = 105;
	localparam int DESC_LEN_LO = 96;
	localparam int LEN_W = 10;
	localparam int WCNT_W = 11;
	// channel limits per lane build
	localparam int MAX_VC_NARROW = 4;
	localparam int MAX_VC_X8 = 2;
	localparam int BUF_DEPTH = 2;

	// data phases needed: length 0 stands for 1024 doublewords
	function automatic logic [WCNT_W-1:0] tdpp_words(
		input logic [DESC_W-1:0] desc);
		logic [WCNT_W:0] dws;
		logic a2;
		dws = '0;
		a2 = desc[DESC_HDR_4DW] ? desc[DESC_ADDR2_4DW] : desc[DESC_ADDR2_3DW];
		dws = {2'h0, desc[DESC_LEN_HI:DESC_LEN_LO]};
		if (dws == 12'h000)
			dws = 12'h400;
		dws = dws + {11'h000, a2} + 12'h001;
		return dws[WCNT_W:1];
	endfunction
endpackage

// ==== hw/tdpp_if.sv ====
// one set of transmit descriptor and data phase signals for one
// virtual channel; instantiate once per channel
`timescale 1ns/100ps
`default_nettype none
interface tdpp_if;
	import tdpp_pkg::*;
	logic req;
	logic [DESC_W-1:0] desc;
	logic ack;
	logic dfr;
	logic payload_valid;
	logic payload_stall;
	logic [DATA_W-1:0] data;

	modport core (input req, desc, dfr, payload_valid, data,
		output ack, payload_stall);
	modport app (output req, desc, dfr, payload_valid, data,
		input ack, payload_stall);
endinterface
`default_nettype wire

// ==== hw/tdpp_app.sv ====
// application end: takes whole packets from user logic and drives the
// descriptor and data phase handshake; user words come lane-aligned
`timescale 1ns/100ps
`default_nettype none
module tdpp_app
	import tdpp_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// port toward the core
	tdpp_if.app port,
	// packet descriptors from user logic
	input wire logic pkt_valid,
	output logic pkt_ready,
	input wire logic [DESC_W-1:0] pkt_desc,
	// payload words from user logic, already placed in their lanes
	input wire logic word_valid,
	output logic word_ready,
	input wire logic [DATA_W-1:0] word_data
);
	typedef enum logic [1:0] {
		TDPP_A_IDLE = 2'b01,
		TDPP_A_SEND = 2'b10
	} tdpp_astate_t;

	tdpp_astate_t state;
	logic req_on;
	logic data_on;
	logic have_word;
	logic valid_ok;
	logic [WCNT_W-1:0] words_left;
	logic take;

	// stall only counts while our own valid is high
	assign take = port.payload_valid & ~port.payload_stall; // see (R9)
	assign pkt_ready = (state == TDPP_A_IDLE);
	assign port.req = req_on;
	// a word left over from the last packet must not ride the request cycle
	assign port.payload_valid = data_on & valid_ok & have_word; // see (R3)
	assign word_ready = data_on & (~have_word | take);
	// framing rises with the request, falls once one word remains
	assign port.dfr = data_on & (~valid_ok | words_left > 11'h001); // see (R2)

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			state <= TDPP_A_IDLE;
		else
		begin
			case (state)
				TDPP_A_IDLE:
					if (pkt_valid)
						state <= TDPP_A_SEND;
				TDPP_A_SEND:
					if (!req_on && !data_on)
						state <= TDPP_A_IDLE;
				default:
					state <= TDPP_A_IDLE;
			endcase
		end
	end

	// request and descriptor held together until acknowledged
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			req_on <= 1'b0;
			port.desc <= '0;
		end
		else if (state == TDPP_A_IDLE && pkt_valid)
		begin
			req_on <= 1'b1; // see (R14)
			port.desc <= pkt_desc;
		end
		else if (port.ack)
			req_on <= 1'b0; // see (R14)
	end

	// framing starts in the request cycle for packets with payload
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			data_on <= 1'b0;
			words_left <= '0;
		end
		else if (state == TDPP_A_IDLE && pkt_valid)
		begin
			data_on <= pkt_desc[DESC_HAS_DATA]; // see (R1) (R16)
			words_left <= tdpp_words(pkt_desc); // see (R17) (R11)
		end
		else if (take)
		begin
			words_left <= words_left - 11'h001;
			if (words_left == 11'h001)
				data_on <= 1'b0; // see (R2)
		end
	end

	// low in the first framing cycle only; data_on is low between packets
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			valid_ok <= 1'b0;
		else
			valid_ok <= data_on; // see (R3)
	end

	// word held unchanged until the core takes it
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			have_word <= 1'b0;
			port.data <= '0;
		end
		else if (word_ready && word_valid)
		begin
			have_word <= 1'b1;
			port.data <= word_data; // see (R10) (R12)
		end
		else if (take)
			have_word <= 1'b0;
	end
endmodule
`default_nettype wire

// ==== tb/tdpp_properties.sv ====
// assertions on one channel's descriptor and data phase signals
// assumes it sits beside the interface joining both ends
`timescale 1ns/100ps
`default_nettype none
module tdpp_properties
	import tdpp_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// interface signals
	input wire logic req,
	input wire logic [DESC_W-1:0] desc,
	input wire logic ack,
	input wire logic dfr,
	input wire logic payload_valid,
	input wire logic payload_stall,
	input wire logic [DATA_W-1:0] data
);
	logic acked;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	sequence take_s;
		payload_valid && !payload_stall;
	endsequence
	sequence last_take_s;
		take_s ##0 !dfr;
	endsequence
	// last take first: a one-word packet may end in its ack cycle
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			acked <= 1'b0;
		else if (payload_valid && !payload_stall && !dfr)
			acked <= 1'b0;
		else if (ack && desc[DESC_HAS_DATA])
			acked <= 1'b1;
	end
	ack_needs_req_a: assert property (ack |-> req)
		else $error("ack without request");
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	pend_stall_a: assert property (req && !ack |-> payload_stall)
		else $error("no stall while descriptor pending");
	hdr4_wait_a: assert property (
		ack && desc[DESC_HDR_4DW] |-> payload_stall)
		else $error("long header word taken with ack");
	first_take_a: assert property (take_s |-> acked || ack)
		else $error("word taken before ack");
	word_hold_a: assert property (
		payload_valid && payload_stall |=> payload_valid && $stable(data))
		else $error("stalled word not held");
	dfr_start_a: assert property (
		$rose(req) && desc[DESC_HAS_DATA] |-> dfr)
		else $error("framing not raised with request");
	valid_late_a: assert property ($rose(req) |-> !payload_valid)
		else $error("valid in the framing start cycle");
	nodata_frame_a: assert property (
		$rose(req) && !desc[DESC_HAS_DATA] |-> !dfr)
		else $error("framing on packet without payload");
	last_take_a: assert property (
		last_take_s |=> !payload_valid)
		else $error("valid beyond final phase");
	req_hold_a: assert property (
		req && !ack |=> req && $stable(desc))
		else $error("request dropped before ack");
endmodule
`default_nettype wire

// ==== tb/tb_tlp_tx_data_phase_port.sv ====
// random packets through both ends of one channel
// assumes package, interface, both ends and checker are compiled
`timescale 1ns/100ps
`default_nettype none
module tb_tlp_tx_data_phase_port
	import tdpp_pkg::*;
;
	logic core_clk, nrst, pkt_valid, pkt_ready, word_valid, word_ready;
	logic desc_grant, link_busy, link_ready, link_valid, fwd_desc_valid;
	logic link_first, link_last, link_hi_start, data_phase_busy;
	logic [DESC_W-1:0] pkt_desc, fwd_desc, d;
	logic [DATA_W-1:0] word_data, link_data, wseq, rseq;
	logic [31:0] rs;
	logic [2:0] e;
	logic [DESC_W-1:0] dq[$];
	logic [2:0] fq[$];
	int fails, samples_checked, cyc, npkt, n;
	tdpp_if bus_if();
	tdpp_app tdpp_app_inst(.core_clk(core_clk), .nrst(nrst),
		.port(bus_if.app), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
		.pkt_desc(pkt_desc), .word_valid(word_valid),
		.word_ready(word_ready), .word_data(word_data));
	tdpp_core tdpp_core_inst(.core_clk(core_clk), .nrst(nrst),
		.port(bus_if.core), .desc_grant(desc_grant), .link_busy(link_busy),
		.fwd_desc(fwd_desc), .fwd_desc_valid(fwd_desc_valid),
		.link_valid(link_valid), .link_ready(link_ready),
		.link_data(link_data), .link_first(link_first),
		.link_last(link_last), .link_hi_start(link_hi_start),
		.data_phase_busy(data_phase_busy));
	tdpp_properties tdpp_properties_inst(.core_clk(core_clk), .nrst(nrst),
		.req(bus_if.req), .desc(bus_if.desc), .ack(bus_if.ack),
		.dfr(bus_if.dfr), .payload_valid(bus_if.payload_valid),
		.payload_stall(bus_if.payload_stall), .data(bus_if.data));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// address bit 2 sits lower for long headers
	function automatic int nwords(input logic [DESC_W-1:0] q);
		int l;
		l = (q[105:96] == 10'h000) ? 1024 : int'(q[105:96]);
		return (l + int'(q[125] ? q[2] : q[34]) + 1) / 2;
	endfunction
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial
	begin
		{nrst, pkt_valid, word_valid, desc_grant, link_busy, link_ready} = '0;
		{pkt_desc, word_data, wseq, rseq} = '0;
		rs = 32'h00012015;
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		wait (npkt >= 150 && fq.size() == 0 && dq.size() == 0);
		give_verdict();
	end
	// pre-edge values are sampled here; drives land after the edge
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc > 60000)
		begin
			fails++;
			give_verdict();
		end
		else if (nrst)
		begin
			rs = xs(rs);
			desc_grant <= rs[1:0] != 2'h0;
			link_busy <= rs[5:2] == 4'h0;
			// long ready-low spells fill the buffer
			link_ready <= cyc[7:6] != 2'h0 && rs[6];
			if (link_busy)
				check(bus_if.payload_stall, 1'b1);
			// a word taken outside its acknowledge cycle needs a data phase
			if (bus_if.payload_valid && !bus_if.payload_stall && !bus_if.ack)
				check(data_phase_busy, 1'b1);
			if (word_valid && word_ready)
				wseq = wseq + 64'h1;
			if (!word_valid || word_ready)
				word_valid <= rs[7] | rs[8];
			word_data <= wseq;
			if (pkt_valid && pkt_ready)
			begin
				dq.push_back(pkt_desc);
				n = nwords(pkt_desc);
				for (int i = 0; i < n && pkt_desc[126]; i++)
					fq.push_back({i == 0, i == n - 1,
						pkt_desc[125] ? pkt_desc[2] : pkt_desc[34]});
				npkt++;
			end
			if (!pkt_valid || pkt_ready)
			begin
				d = {xs(rs), rs, ~rs, xs(~rs)};
				d[105:96] = (npkt == 0) ? 10'h000 : {7'h00, rs[12:10]};
				d[126] = (npkt == 0) | rs[13];
				pkt_valid <= rs[9] | rs[14];
				pkt_desc <= d;
			end
			if (fwd_desc_valid)
				check(fwd_desc, dq.pop_front());
			if (link_valid && link_ready)
			begin
				e = fq.pop_front();
				check(link_data, rseq);
				check({link_first, link_last, link_first & link_hi_start},
					{e[2], e[1], e[2] & e[0]});
				rseq = rseq + 64'h1;
			end
		end
	end
endmodule
`default_nettype wire
